// File: src/opt_pkg.sv
// Purpose: Shared constants, register map and carriers of the one-shot PWM timer
// Assumes: 32-bit Avalon-MM slave, word index is address[11:2]
// Notes:   Narrow registers sit in the low bits of the data word
package opt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_MODE     = 10'h120;
  localparam logic [9:0] IDX_CTL_ONE  = 10'h121;
  localparam logic [9:0] IDX_IRQ_EN   = 10'h122;
  localparam logic [9:0] IDX_STATUS   = 10'h123;
  localparam logic [9:0] IDX_COUNTER  = 10'h124;
  localparam logic [9:0] IDX_IRQ_CTL  = 10'h125;
  localparam logic [9:0] IDX_GEN_A    = 10'h128;  // A..D at 128h..12Bh
  localparam logic [9:0] IDX_CTL_TWO  = 10'h130;
  localparam logic [9:0] IDX_FILTER   = 10'h131;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_CAP_A   = 0;  // Capture enables A..D in bits 3:0
  localparam int MODE_BUF_C   = 4;
  localparam int MODE_BUF_D   = 5;
  localparam int MODE_MULTI   = 6;
  localparam int MODE_RUN     = 7;
  localparam int C1_INIT_B    = 1;
  localparam int C1_SRC_LO    = 4;  // Count source select in bits 6:4
  localparam int C1_CLEAR     = 7;
  localparam int C2_POL_B     = 0;
  localparam int C2_POL_C     = 1;
  localparam int C2_POL_D     = 2;
  localparam int C2_STOP      = 5;
  localparam int C2_TRG_LO    = 6;
  localparam int C2_TRG_HI    = 7;
  localparam int FS_TRIGGER   = 4;
  localparam int FS_CLK_LO    = 6;
  localparam int FS_CLK_HI    = 7;
  localparam int ST_OVF       = 4;  // Status bits 3:0 are matches or captures A..D
  localparam int IC_REQ       = 3;  // Priority field in bits 2:0

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and masks
  localparam logic [7:0] CTL_TWO_RST  = 8'h18;
  localparam logic [7:0] CTL_TWO_RSV  = 8'h18;  // Unassigned bits read as one
  localparam logic [7:0] CTL_TWO_WMSK = 8'hE7;
  localparam logic [7:0] FILTER_WMSK  = 8'hDF;
  localparam logic [7:0] REG8_RST     = 8'h00;
  localparam logic [15:0] REG16_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Counts of cycles
  localparam logic [4:0] PRE_F2       = 5'h01;  // Prescaler tick masks
  localparam logic [4:0] PRE_F4       = 5'h03;
  localparam logic [4:0] PRE_F8       = 5'h07;
  localparam logic [4:0] PRE_F32      = 5'h1F;
  localparam int FILT_SAMPLES         = 3;      // Equal samples needed to move

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers and states
  typedef struct packed {
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } opt_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } opt_av_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} opt_state_t;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] opt_merge16(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    opt_merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
  endfunction : opt_merge16

  // Prescaler tick: all masked bits high
  function automatic logic opt_pre_tick(input logic [4:0] pre, input logic [4:0] msk);
    opt_pre_tick = ((pre & msk) == msk);
  endfunction : opt_pre_tick

endpackage : opt_pkg

// File: src/opt_noise_filter.sv
// Purpose: Digital noise filter for one timer input pin
// Assumes: pin_in synchronous to clk, sample_en is a one-cycle pulse
// Notes:   With enable set, output moves only after FILT_SAMPLES equal samples; bypassed, it follows pin_in one clock later
module opt_noise_filter (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sample_en,
  input  wire logic enable,
  input  wire logic pin_in,
  output wire logic pin_out
);
  import opt_pkg::*;

  logic [FILT_SAMPLES-1:0] samples;
  logic                    level;
  logic                    pin_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Sampling shift and settled level
  wire all_high = &samples;
  wire all_low  = ~|samples;

  always_ff @(posedge clk) begin
    if (reset) begin
      samples <= '0;
      level   <= 1'b0;
      pin_q   <= 1'b0;
    end else begin
      pin_q <= pin_in;
      if (sample_en) begin
        samples <= {samples[FILT_SAMPLES-2:0], pin_in};
      end
      if (all_high) begin
        level <= 1'b1;
      end else if (all_low) begin
        level <= 1'b0;
      end
    end
  end

  // Bypass still goes through a flop so both paths share latency class
  assign pin_out = enable ? level : pin_q;

endmodule : opt_noise_filter

// File: src/opt_timer_top.sv
// Purpose: 16-bit up-counting timer with triggered one-shot PWM output on pin B
// Assumes: Single 10 MHz clock, synchronous active-high reset, pins synchronous
// Notes:   Oscillator inputs are one-cycle enable ticks, not clocks
// Notes on behaviour
// - Polarity bits set active level of pins B, C, D in multi-output mode only.
// - Period-stop bit 0 keeps counting after period match; 1 stops there.
// - Trigger edge field: 00 off, 01 rising, 10 falling, 11 both edges.
// - Filter select holds per-pin enables for capture pins A-D and trigger.
// - Filter clock field: 00 clk/32, 01 clk/8, 10 clk, 11 count source.
// - Trigger filter settings act only in single-pulse mode with trigger enabled.
// - Register A period, B end change point, C wait change point, on pin B.
// - Register D sets pin D in multi-output mode; with buffer bit set, it feeds next B value.
// - Five request sources merge into one request flag and one priority field.
// - Request flag is set while any status flag and its enable are set.
// - Request drops as soon as flag or enable is zero; nothing latched.
// - A further source while request is high leaves it high, no new edge.
// - Acknowledge leaves status flags alone; software clears them in handler.
// - Counter write colliding with automatic period clear is lost; counter becomes 0.
// - Read right after write may show old value; software inserts a short jump.
// - Unfiltered capture copies counter one or two cycles after the pin edge.
// - Period is A+1, wait is C+1, active width is B minus C cycles.
// - Period-stop match halts, restores pin B initial level, holds or clears counter.
//
// Implementation choice: register access over Avalon-MM.
module opt_timer_top (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire opt_pkg::opt_av_req_t av_req,
  output      opt_pkg::opt_av_rsp_t av_rsp,
  input  wire logic                trigger_pin,
  input  wire logic [3:0]          capture_pin,
  input  wire logic                ext_clk_pin,
  input  wire logic                fast_osc_40m,
  input  wire logic                fast_osc_divided,
  output wire logic                output_pin_b,
  output wire logic                output_pin_c,
  output wire logic                output_pin_d,
  output wire logic                irq_request_flag
);
  import opt_pkg::*;

  logic [7:0]  timer_mode_reg;
  logic [7:0]  pulse_control_one;
  logic [7:0]  pulse_control_two;
  logic [7:0]  filter_select;
  logic [4:0]  timer_irq_enable;
  logic [4:0]  timer_status;
  logic [2:0]  irq_priority_field;
  logic [15:0] timer_counter;
  logic [15:0] gen_reg [4];
  logic [15:0] next_counter;
  logic        ack;
  logic [31:0] rd_q;
  logic [31:0] rd_mux;
  logic [4:0]  pre;
  logic        ext_q;
  logic        ext_prev;
  logic        pin_b;
  logic        pin_c;
  logic        pin_d;
  logic        next_pin_b;
  logic        irq_q;
  logic [4:0]  filt_out;
  logic [4:0]  filt_prev;
  opt_state_t  state;
  opt_state_t  next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, read data captured on the first cycle
  wire       req_any = av_req.read | av_req.write;
  wire [9:0] idx     = av_req.address[11:2];
  wire [3:0] be      = av_req.byteenable;
  wire [31:0] wd     = av_req.writedata;
  wire       wr_en   = av_req.write & ack;
  wire       gen_hit = (idx[9:2] == IDX_GEN_A[9:2]);
  wire [1:0] gen_sel = idx[1:0];

  assign av_rsp.waitrequest = req_any & ~ack;
  assign av_rsp.readdata    = rd_q;

  // Register read data is a snapshot; irq_q lags a write by one more cycle, so a back-to-back read of it can be stale
  always_ff @(posedge clk) begin
    if (reset) begin
      ack  <= 1'b0;
      rd_q <= RD_ZERO;
    end else begin
      ack <= req_any & ~ack;
      if (av_req.read & ~ack) begin
        rd_q <= rd_mux;
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = RD_ZERO;
    if (gen_hit) begin
      rd_mux = {16'h0000, gen_reg[gen_sel]};
    end else begin
      case (idx)
        IDX_MODE:    rd_mux = {24'h00_0000, timer_mode_reg};
        IDX_CTL_ONE: rd_mux = {24'h00_0000, pulse_control_one};
        IDX_IRQ_EN:  rd_mux = {27'h000_0000, timer_irq_enable};
        IDX_STATUS:  rd_mux = {27'h000_0000, timer_status};
        IDX_COUNTER: rd_mux = {16'h0000, timer_counter};
        IDX_IRQ_CTL: rd_mux = {28'h000_0000, irq_q, irq_priority_field};
        IDX_CTL_TWO: rd_mux = {24'h00_0000, pulse_control_two | CTL_TWO_RSV};
        IDX_FILTER:  rd_mux = {24'h00_0000, filter_select};
        default:     rd_mux = RD_ZERO;
      endcase
    end
  end

  // Write strobes
  wire wr_lo    = wr_en & be[0];
  wire wr_mode  = wr_lo & (idx == IDX_MODE);
  wire wr_ctl1  = wr_lo & (idx == IDX_CTL_ONE);
  wire wr_ien   = wr_lo & (idx == IDX_IRQ_EN);
  wire wr_stat  = wr_lo & (idx == IDX_STATUS);
  wire wr_ictl  = wr_lo & (idx == IDX_IRQ_CTL);
  wire wr_ctl2  = wr_lo & (idx == IDX_CTL_TWO);
  wire wr_filt  = wr_lo & (idx == IDX_FILTER);
  wire wr_cnt   = wr_en & (idx == IDX_COUNTER) & (be[0] | be[1]);
  wire wr_gen   = wr_en & gen_hit & (be[0] | be[1]);

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire       multi     = timer_mode_reg[MODE_MULTI];
  wire       count_run = timer_mode_reg[MODE_RUN];
  wire       buf_d     = timer_mode_reg[MODE_BUF_D];
  wire       init_b    = pulse_control_one[C1_INIT_B];
  wire       clr_per   = pulse_control_one[C1_CLEAR];
  wire [2:0] src_sel   = pulse_control_one[C1_SRC_LO +: 3];
  wire       per_stop  = pulse_control_two[C2_STOP];
  wire [1:0] trg_edge  = pulse_control_two[C2_TRG_HI:C2_TRG_LO];
  wire [1:0] filt_clk  = filter_select[FS_CLK_HI:FS_CLK_LO];
  // Trigger only counts in single-pulse mode
  wire       trg_en    = ~multi & (trg_edge != 2'b00);

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler and count source select
  wire ext_tick = ext_q & ~ext_prev;
  wire src_tick = (src_sel == 3'b000) ? 1'b1 :
                  (src_sel == 3'b001) ? opt_pre_tick(pre, PRE_F2) :
                  (src_sel == 3'b010) ? opt_pre_tick(pre, PRE_F4) :
                  (src_sel == 3'b011) ? opt_pre_tick(pre, PRE_F8) :
                  (src_sel == 3'b100) ? opt_pre_tick(pre, PRE_F32) :
                  (src_sel == 3'b101) ? ext_tick :
                  (src_sel == 3'b110) ? fast_osc_40m : fast_osc_divided;
  // Filter sampling clock
  wire filt_tick = (filt_clk == 2'b00) ? opt_pre_tick(pre, PRE_F32) :
                   (filt_clk == 2'b01) ? opt_pre_tick(pre, PRE_F8) :
                   (filt_clk == 2'b10) ? 1'b1 : src_tick;

  always_ff @(posedge clk) begin
    if (reset) begin
      pre      <= 5'h00;
      ext_q    <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      pre      <= pre + 5'h01;
      ext_q    <= ext_clk_pin;
      ext_prev <= ext_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input filters: slot 4 is the trigger, 3:0 capture pins A..D
  wire [4:0] pins_raw = {trigger_pin, capture_pin};
  // Trigger filter only meaningful with an enabled trigger
  wire [4:0] filt_en  = {filter_select[FS_TRIGGER] & trg_en, filter_select[3:0]};

  for (genvar g = 0; g < 5; g++) begin : g_filt
    opt_noise_filter u_filt (
      .clk       (clk),
      .reset     (reset),
      .sample_en (filt_tick),
      .enable    (filt_en[g]),
      .pin_in    (pins_raw[g]),
      .pin_out   (filt_out[g])
    );
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      filt_prev <= 5'h00;
    end else begin
      filt_prev <= filt_out;
    end
  end

  wire trg_rise  = filt_out[4] & ~filt_prev[4];
  wire trg_fall  = ~filt_out[4] & filt_prev[4];
  wire trg_hit   = (trg_edge[0] & trg_rise) | (trg_edge[1] & trg_fall);
  // Pin edge to copy takes one or two clocks with filter bypassed
  wire [3:0] cap_hit = filt_out[3:0] & ~filt_prev[3:0] & timer_mode_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Compare matches, only on count-source ticks
  wire       tick      = (state == ST_RUN) & src_tick;
  wire [3:0] match;
  for (genvar m = 0; m < 4; m++) begin : g_match
    assign match[m] = tick & (timer_counter == gen_reg[m]);
  end
  wire stop_hit   = match[0] & per_stop;
  wire overflow   = tick & (timer_counter == CNT_MAX);
  wire trig_start = trg_en & trg_hit & count_run & (state != ST_IDLE);
  wire buf_xfer   = match[0] & buf_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Run state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (count_run) begin
                  next_state = (trg_en & per_stop) ? ST_ARMED : ST_RUN;
                end
      ST_ARMED: if (trg_hit & trg_en) begin
                  next_state = ST_RUN;
                end
      ST_RUN:   if (stop_hit) begin
                  next_state = trg_en ? ST_ARMED : ST_IDLE;
                end
      default:  next_state = ST_IDLE;
    endcase
    if (!count_run) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter; automatic clear beats a colliding software write
  always_comb begin
    next_counter = timer_counter;
    if (trig_start) begin
      next_counter = REG16_RST;
    end else if (match[0] & clr_per) begin
      next_counter = REG16_RST;
    end else if (wr_cnt) begin
      next_counter = opt_merge16(timer_counter, wd, be);
    end else if (tick & ~stop_hit) begin
      next_counter = timer_counter + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_counter <= REG16_RST;
    end else begin
      timer_counter <= next_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General registers: capture, then software, then buffer transfer
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int j = 0; j < 4; j++) begin
        gen_reg[j] <= REG16_RST;
      end
    end else begin
      for (int j = 0; j < 4; j++) begin
        if (cap_hit[j]) begin
          gen_reg[j] <= timer_counter;
        end else if (wr_gen && gen_sel == 2'(j)) begin
          gen_reg[j] <= opt_merge16(gen_reg[j], wd, be);
        end else if (j == 1 && buf_xfer) begin
          gen_reg[j] <= gen_reg[3];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers; stop without trigger drops the run bit
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_mode_reg     <= REG8_RST;
      pulse_control_one  <= REG8_RST;
      pulse_control_two  <= CTL_TWO_RST;
      filter_select      <= REG8_RST;
      timer_irq_enable   <= 5'h00;
      irq_priority_field <= 3'h0;
    end else begin
      if (wr_mode) begin
        timer_mode_reg <= wd[7:0];
      end else if (stop_hit & ~trg_en) begin
        timer_mode_reg[MODE_RUN] <= 1'b0;
      end
      if (wr_ctl1) begin
        pulse_control_one <= wd[7:0];
      end
      if (wr_ctl2) begin
        pulse_control_two <= (wd[7:0] & CTL_TWO_WMSK) | CTL_TWO_RSV;
      end
      if (wr_filt) begin
        filter_select <= wd[7:0] & FILTER_WMSK;
      end
      if (wr_ien) begin
        timer_irq_enable <= wd[4:0];
      end
      if (wr_ictl) begin
        irq_priority_field <= wd[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags: write 0 clears, hardware set wins in the same cycle
  wire [4:0] stat_set = {overflow, match | cap_hit};
  wire [4:0] stat_clr = wr_stat ? ~wd[4:0] : 5'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_status <= 5'h00;
      irq_q        <= 1'b0;
    end else begin
      timer_status <= (timer_status & ~stat_clr) | stat_set;
      // Level merge: follows flags and enables, never latched
      irq_q        <= |(timer_status & timer_irq_enable);
    end
  end
  assign irq_request_flag = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin B one-shot sequence; multi-output mode compares against register B
  function automatic logic pwm_level(input logic run, input logic [15:0] cnt,
                                     input logic [15:0] cmp, input logic pol);
    pwm_level = (run && cnt < cmp) ? pol : ~pol;
  endfunction : pwm_level

  always_comb begin
    next_pin_b = pin_b;
    if (multi) begin
      next_pin_b = pwm_level(count_run, timer_counter, gen_reg[1],
                             pulse_control_two[C2_POL_B]);
    end else if (state == ST_IDLE || stop_hit || trig_start) begin
      next_pin_b = init_b;
    end else if (match[2]) begin
      next_pin_b = ~init_b;
    end else if (match[1]) begin
      next_pin_b = init_b;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_b <= 1'b0;
      pin_c <= 1'b0;
      pin_d <= 1'b0;
    end else begin
      pin_b <= next_pin_b;
      pin_c <= multi & pwm_level(count_run, timer_counter, gen_reg[2],
                                 pulse_control_two[C2_POL_C]);
      pin_d <= multi & pwm_level(count_run, timer_counter, gen_reg[3],
                                 pulse_control_two[C2_POL_D]);
    end
  end

  assign output_pin_b = pin_b;
  assign output_pin_c = pin_c;
  assign output_pin_d = pin_d;

endmodule : opt_timer_top

// File: bench/opt_timer_assertions.sv
// Purpose: Port-level checks of the one-shot timer
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module, sees its ports only
module opt_timer_checker
  import opt_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire opt_av_req_t av_req,
  input wire opt_av_rsp_t av_rsp,
  input wire logic        output_pin_c,
  input wire logic        output_pin_d,
  input wire logic        irq_request_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire       req = av_req.read | av_req.write;
  wire [9:0] idx = av_req.address[11:2];
  wire       acc = req & ~av_rsp.waitrequest;
  wire       rda = acc & av_req.read;
  wire       wra = acc & av_req.write;
  wire       map = (idx >= IDX_MODE && idx <= IDX_IRQ_CTL) || (idx >= IDX_GEN_A && idx <= 10'h12B)
                   || idx == IDX_CTL_TWO || idx == IDX_FILTER;
  // Shadow of the multi-output bit; pins lag it, so two samples are needed
  logic multi;
  always_ff @(posedge clk) begin
    if (reset) multi <= 1'b0;
    else if (wra && idx == IDX_MODE) multi <= av_req.writedata[MODE_MULTI];
  end
  //////////////////////////////////////////////////////////////////////////////
  a_one_wait: assert property (req && av_rsp.waitrequest |=> !av_rsp.waitrequest)
    else $error("wait longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq_request_flag && !output_pin_c)
    else $error("outputs active after reset");
  a_unmapped_zero: assert property (rda && !map |-> av_rsp.readdata == RD_ZERO)
    else $error("unmapped read not zero");
  a_rsv_ones: assert property (rda && idx == IDX_CTL_TWO |-> av_rsp.readdata[4:3] == 2'b11)
    else $error("control two spare bits not one");
  a_filt_rsv: assert property (rda && idx == IDX_FILTER |-> !av_rsp.readdata[5])
    else $error("filter spare bit not zero");
  a_read_hold: assert property (rda |=> $stable(av_rsp.readdata))
    else $error("read data moved");
  a_irq_mask: assert property (wra && idx == IDX_IRQ_EN && av_req.writedata[4:0] == 5'h00
    |-> ##2 !irq_request_flag) else $error("request kept with all enables off");
  a_single_cd: assert property (!multi && !$past(multi) |-> !output_pin_c && !output_pin_d)
    else $error("pins c d active in single mode");
endmodule : opt_timer_checker

bind opt_timer_top opt_timer_checker u_chk (.clk(clk), .reset(reset), .av_req(av_req),
  .av_rsp(av_rsp), .output_pin_c(output_pin_c), .output_pin_d(output_pin_d),
  .irq_request_flag(irq_request_flag));

// File: bench/opt_far_end.sv
// Purpose: Trigger source and pulse load on pin B
// Assumes: Trigger level requested by the bench
// Notes:   Width counts cycles away from the idle level while watched
module opt_far_end (
  input  wire logic  clk,
  input  wire logic  want_lvl,
  input  wire logic  idle_lvl,
  input  wire logic  watch,
  input  wire logic  pin_b,
  output logic       trigger_pin,
  output logic       done,
  output logic [15:0] width
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt;
  initial begin
    trigger_pin = 1'b0;
    done = 1'b0;
    cnt = 16'h0000;
  end
  // Trigger moves one edge after the request; pulse width reported on return to idle
  always @(posedge clk) begin
    trigger_pin <= want_lvl;
    done <= 1'b0;
    if (!watch) cnt <= 16'h0000;
    else if (pin_b != idle_lvl) cnt <= cnt + 16'h0001;
    else if (cnt != 16'h0000) begin
      width <= cnt;
      done <= 1'b1;
      cnt <= 16'h0000;
    end
  end
endmodule : opt_far_end

// File: bench/tb_top.sv
// Purpose: Self-checking bench of the one-shot timer
// Assumes: Avalon-MM register access, count source f1
// Notes:   Read data and pulse widths checked against a queue of notes
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import opt_pkg::*;
  typedef struct {string nm; logic [15:0] e; logic [15:0] m;} opt_note_t;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  opt_av_req_t req = '0;
  opt_av_rsp_t rsp;
  logic        want = 1'b0, idle = 1'b0, watch = 1'b0;
  logic [3:0]  cap = 4'h0;
  logic        trig, pin_b, done;
  logic [15:0] width, vb, vc;
  logic [7:0]  v;
  opt_note_t   q[$];
  opt_note_t   n;
  int          n_fail = 0, compares = 0, m;
  always #50 clk = ~clk;
  opt_timer_top DUT (.clk(clk), .reset(reset), .av_req(req), .av_rsp(rsp), .trigger_pin(trig),
    .capture_pin(cap), .ext_clk_pin(1'b0), .fast_osc_40m(1'b0), .fast_osc_divided(1'b0),
    .output_pin_b(pin_b), .output_pin_c(), .output_pin_d(), .irq_request_flag());
  opt_far_end FAR (.clk(clk), .want_lvl(want), .idle_lvl(idle), .watch(watch), .pin_b(pin_b),
    .trigger_pin(trig), .done(done), .width(width));
  //////////////////////////////////////////////////////////////////////////////
  // One bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
    int i;
    @(posedge clk);
    req.address <= {idx, 2'b00};
    req.write <= w;
    req.read <= ~w;
    req.byteenable <= 4'h3;
    req.writedata <= {16'h0000, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp.waitrequest !== 1'b0 && i < 50);
    if (i >= 50) n_fail++;
    req.write <= 1'b0;
    req.read <= 1'b0;
  endtask : bus
  task automatic rd(input string nm, input logic [9:0] idx, input logic [15:0] e, m);
    q.push_back('{nm, e & m, m});
    bus(1'b0, idx, 16'h0000);
  endtask : rd
  task automatic finish_test;
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////////////
  // Results in arrival order; a result with no note is a failure
  always @(negedge clk) begin
    if ((req.read && rsp.waitrequest === 1'b0) || done === 1'b1) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("[FAIL] note queue exp 1 got 0");
      end else begin
        n = q.pop_front();
        `CHK(n.nm, n.e, (done ? width : rsp.readdata[15:0]) & n.m)
      end
    end
  end
  // Watchdog well beyond the roughly 650 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end
  initial begin
    void'($urandom(82021));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd("ctl_two", IDX_CTL_TWO, 16'h0018, 16'h00FF);
    rd("filter", IDX_FILTER, 16'h0000, 16'h00FF);
    rd("unmapped", 10'h000, 16'h0000, 16'hFFFF);
    repeat (4) begin
      v = 8'($urandom());
      vb = 16'($urandom());
      bus(1'b1, IDX_CTL_TWO, {8'h00, v});
      rd("ctl_two", IDX_CTL_TWO, {8'h00, v & CTL_TWO_WMSK | CTL_TWO_RSV}, 16'h00FF);
      bus(1'b1, IDX_FILTER, {8'h00, v});
      rd("filter", IDX_FILTER, {8'h00, v & FILTER_WMSK}, 16'h00FF);
      bus(1'b1, IDX_COUNTER, vb);
      rd("counter", IDX_COUNTER, vb, 16'hFFFF);
    end
    bus(1'b1, IDX_FILTER, 16'h0090); // Trigger filtered at the undivided clock
    for (int k = 0; k < 6; k++) begin
      m = k % 3 + 1;
      vc = 16'($urandom_range(4, 1));
      vb = vc + 16'($urandom_range(5, 1));
      watch <= 1'b0;
      want <= (m != 2); // Parked on the selected level while stopped
      bus(1'b1, IDX_MODE, 16'h0000);
      bus(1'b1, IDX_CTL_ONE, m == 2 ? 16'h0082 : 16'h0080); // f1 kept, no osc switch
      bus(1'b1, IDX_GEN_A, vb + 16'h0003);
      bus(1'b1, IDX_GEN_A + 10'h001, vb);
      bus(1'b1, IDX_GEN_A + 10'h002, vc);
      bus(1'b1, IDX_CTL_TWO, {8'h00, 2'(m), 6'h20});
      bus(1'b1, IDX_MODE, 16'h0080);
      idle <= (m == 2);
      repeat (3) @(posedge clk);
      watch <= 1'b1;
      if (m != 3) begin
        want <= ~want; // Unselected edge must not fire
        repeat (30) @(posedge clk);
      end
      q.push_back('{"width", vb - vc, 16'hFFFF});
      want <= ~want;
      repeat (40) @(posedge clk); // Pulse ends and pin returns idle
    end
    // Capture A with the count stopped copies the held counter value
    vb = 16'($urandom());
    bus(1'b1, IDX_MODE, 16'h0001);
    bus(1'b1, IDX_COUNTER, vb);
    cap <= 4'h1; // Four cycles wide
    repeat (4) @(posedge clk);
    cap <= 4'h0;
    rd("capture_a", IDX_GEN_A, vb, 16'hFFFF);
    bus(1'b1, IDX_IRQ_CTL, 16'h0005);
    bus(1'b1, IDX_IRQ_EN, 16'h0001);
    rd("irq_ctl", IDX_IRQ_CTL, 16'h000D, 16'h000F);
    bus(1'b1, IDX_IRQ_EN, 16'h0000);
    rd("irq_ctl", IDX_IRQ_CTL, 16'h0005, 16'h000F);
    bus(1'b1, IDX_IRQ_EN, 16'h0003);
    rd("status", IDX_STATUS, 16'h0003, 16'h0003);
    rd("irq_ctl", IDX_IRQ_CTL, 16'h000D, 16'h000F);
    bus(1'b1, IDX_STATUS, 16'h001C);
    rd("irq_ctl", IDX_IRQ_CTL, 16'h0005, 16'h000F);
    rd("status", IDX_STATUS, 16'h0000, 16'h0003);
    finish_test;
  end
endmodule : tb_top
